// ===== logic/bsttr_pkg.sv
/*
 * Package for the test-port data registers: instruction codes, register
 * lengths, identification field layout and link signal groupings.
 * Assumes the test clock is sampled by a much faster system clock.
 */
package bsttr_pkg;

    localparam int IR_LEN    = 3;
    localparam int ID_LEN    = 32;
    localparam int BSR_LEN   = 8;
    localparam int SYNC_LEN  = 2;

    localparam logic [IR_LEN-1:0] INS_EXTEST  = 3'h0;
    localparam logic [IR_LEN-1:0] INS_IDCODE  = 3'h1;
    localparam logic [IR_LEN-1:0] INS_SAMPLE  = 3'h2;
    localparam logic [IR_LEN-1:0] INS_CLAMP   = 3'h3;
    localparam logic [IR_LEN-1:0] INS_HIGHZ   = 3'h4;
    localparam logic [IR_LEN-1:0] INS_BYPASS  = 3'h7;
    localparam logic [IR_LEN-1:0] IR_CAPTURE  = 3'h1;

    // Identification layout: revision | part | maker | fixed one
    localparam int ID_REV_LSB   = 28;
    localparam int ID_PART_LSB  = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam logic ID_FIXED_ONE = 1'b1;

    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bsttr_state_type;

    // Pins from the external tester
    typedef struct packed {
        logic clk;
        logic mode;
        logic data;
    } bsttr_link_type;

endpackage : bsttr_pkg

// ===== logic/bsttr_sync.sv
/*
 * Two-stage synchroniser for the test-port pins plus edge detection.
 * Assumes the pins are asynchronous to clk.
 */
`timescale 1ns/1ps
module bsttr_sync
    import bsttr_pkg::*;
(
    // System
    input  wire logic           clk,
    input  wire logic           sys_rst,
    // Raw pins
    input  wire bsttr_link_type pins_in,
    // Synchronised view
    output bsttr_link_type      pins_sync,
    output logic                rise,
    output logic                fall
);

    bsttr_link_type meta_r;
    bsttr_link_type sync_r;
    logic           clk_prev_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r     <= '0;
            sync_r     <= '0;
            clk_prev_r <= 1'b0;
        end else begin
            meta_r     <= pins_in;
            sync_r     <= meta_r;
            clk_prev_r <= sync_r.clk;
        end
    end

    assign pins_sync = sync_r;
    assign rise      = sync_r.clk & ~clk_prev_r;
    assign fall      = ~sync_r.clk & clk_prev_r;

endmodule : bsttr_sync

// ===== logic/bsttr_regs.sv
/*
 * Test data registers behind the test access port: bypass, boundary scan
 * and identification, plus the instruction register and TAP sequencer.
 * Assumes an external tester drives the test clock far slower than clk.
 */
`timescale 1ns/1ps
module bsttr_regs
    import bsttr_pkg::*;
#(
    parameter logic [3:0]  ID_REVISION = 4'h0,     // Arbitrary value
    parameter logic [15:0] ID_PART     = 16'h0A5A, // Arbitrary value
    parameter logic [10:0] ID_MAKER    = 11'h2B3   // Arbitrary value
)
(
    // System
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Test port pins
    input  wire logic               test_port_clock,
    input  wire logic               test_mode_select,
    input  wire logic               test_serial_in,
    output logic                    test_serial_out,
    output logic                    test_serial_out_oe_n,
    // Boundary cells
    input  wire logic [BSR_LEN-1:0] cell_capture,
    output logic [BSR_LEN-1:0]      cell_drive,
    output logic                    cells_test_mode,
    output logic                    cells_high_z
);

    bsttr_link_type  pins_raw;
    bsttr_link_type  pins;
    logic            tck_rise;
    logic            tck_fall;

    bsttr_state_type state_r;
    bsttr_state_type state_nxt;
    logic [IR_LEN-1:0]  ir_shift_r;
    logic [IR_LEN-1:0]  ir_latch_r;
    logic               bypass_r;
    logic [BSR_LEN-1:0] bsr_shift_r;
    logic [BSR_LEN-1:0] bsr_latch_r;
    logic [ID_LEN-1:0]  id_shift_r;
    logic [ID_LEN-1:0]  id_latch_r;
    logic               tdo_r;
    logic               tdo_en_r;

    assign pins_raw = '{clk: test_port_clock, mode: test_mode_select, data: test_serial_in};

    bsttr_sync u_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .pins_in   (pins_raw),
        .pins_sync (pins),
        .rise      (tck_rise),
        .fall      (tck_fall)
    );

    function automatic bsttr_state_type next_state(input bsttr_state_type s, input logic m);
        case (s)
            ST_RESET:    next_state = m ? ST_RESET    : ST_IDLE;
            ST_IDLE:     next_state = m ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = m ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = m ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = m ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = m ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = m ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = m ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    endfunction : next_state

    assign state_nxt = tck_rise ? next_state(state_r, pins.mode) : state_r;

    // Instruction decode; the reset state overrides the latch
    wire in_reset   = (state_r == ST_RESET);
    wire sel_id     = in_reset || (ir_latch_r == INS_IDCODE);
    wire sel_bypass = !in_reset && ((ir_latch_r == INS_BYPASS) || (ir_latch_r == INS_CLAMP)
                      || (ir_latch_r == INS_HIGHZ));
    wire sel_bsr    = !in_reset && ((ir_latch_r == INS_EXTEST) || (ir_latch_r == INS_SAMPLE));
    wire sel_none   = !(sel_id || sel_bypass || sel_bsr);

    wire dr_cap   = tck_rise && (state_r == ST_CAP_DR);
    wire dr_shift = tck_rise && (state_r == ST_SHIFT_DR);
    wire ir_cap   = tck_rise && (state_r == ST_CAP_IR);
    wire ir_shift = tck_rise && (state_r == ST_SHIFT_IR);
    wire dr_upd   = tck_fall && (state_r == ST_UPD_DR);
    wire ir_upd   = tck_fall && (state_r == ST_UPD_IR);

    wire [ID_LEN-1:0] id_code = {ID_REVISION, ID_PART, ID_MAKER, ID_FIXED_ONE};

    // Unimplemented codes fall back to bypass so the chain never breaks
    wire serial_tail = (state_r == ST_SHIFT_IR) ? ir_shift_r[0] :
                       sel_id                   ? id_shift_r[0] :
                       sel_bsr                  ? bsr_shift_r[0] : bypass_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Instruction register: shift stage and latched output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ir_shift_r <= IR_CAPTURE;
            ir_latch_r <= INS_IDCODE;
        end else begin
            if (ir_cap) ir_shift_r <= IR_CAPTURE;
            else if (ir_shift) ir_shift_r <= {pins.data, ir_shift_r[IR_LEN-1:1]};
            if (in_reset) ir_latch_r <= INS_IDCODE;
            else if (ir_upd) ir_latch_r <= ir_shift_r;
        end
    end

    // Bypass: one stage between serial input and output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bypass_r <= 1'b0;
        end else if ((sel_bypass || sel_none) && dr_cap) begin
            bypass_r <= 1'b0;
        end else if ((sel_bypass || sel_none) && dr_shift) begin
            bypass_r <= pins.data;
        end
    end

    // Boundary scan: shift path and latched parallel output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bsr_shift_r <= '0;
            bsr_latch_r <= '0;
        end else begin
            if (sel_bsr && dr_cap) bsr_shift_r <= cell_capture;
            else if (sel_bsr && dr_shift) bsr_shift_r <= {pins.data, bsr_shift_r[BSR_LEN-1:1]};
            if (sel_bsr && dr_upd) bsr_latch_r <= bsr_shift_r;
        end
    end

    // Identification: 32-bit shift stage and latch
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            id_shift_r <= '0;
            id_latch_r <= '0;
        end else begin
            if (sel_id && dr_cap) id_shift_r <= id_code;
            else if (sel_id && dr_shift) id_shift_r <= {pins.data, id_shift_r[ID_LEN-1:1]};
            if (sel_id && dr_upd) id_latch_r <= id_shift_r;
        end
    end

    // Output changes on the falling test clock, as a tester expects
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdo_r    <= 1'b0;
            tdo_en_r <= 1'b0;
        end else if (tck_fall) begin
            tdo_r    <= serial_tail;
            tdo_en_r <= (state_r == ST_SHIFT_DR) || (state_r == ST_SHIFT_IR);
        end
    end

    assign test_serial_out      = tdo_r;
    assign test_serial_out_oe_n = ~tdo_en_r;
    assign cell_drive           = bsr_latch_r;
    assign cells_test_mode      = !in_reset && ((ir_latch_r == INS_EXTEST) || (ir_latch_r == INS_CLAMP));
    assign cells_high_z         = !in_reset && (ir_latch_r == INS_HIGHZ);

    id_reset_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_RESET) |=> (ir_latch_r == INS_IDCODE))
        else $error("instruction not forced to identify in reset");

    id_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dr_cap && sel_id) |=> (id_shift_r == id_code && id_shift_r[0] == ID_FIXED_ONE))
        else $error("identification code not captured");

    // Checks the serial mux, not the select decode, so a wrong select shows up
    id_selected_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_SHIFT_DR && ir_latch_r == INS_IDCODE) |-> (serial_tail == id_shift_r[0]))
        else $error("identification not on serial path");

    bypass_stage_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dr_shift && sel_bypass) |=> (bypass_r == $past(pins.data)))
        else $error("bypass stage did not take serial input");

    bypass_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dr_cap && sel_bypass) |=> (bypass_r == 1'b0))
        else $error("bypass stage not cleared on capture");

    bypass_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_r == ST_SHIFT_DR && (ir_latch_r == INS_BYPASS || ir_latch_r == INS_CLAMP
            || ir_latch_r == INS_HIGHZ)) |-> (serial_tail == bypass_r))
        else $error("bypass not on serial path");

    bsr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!dr_upd) |=> $stable(bsr_latch_r))
        else $error("boundary latch moved outside update");

    id_shift_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dr_shift && sel_id) |=> (id_shift_r[ID_LEN-2:0] == $past(id_shift_r[ID_LEN-1:1])))
        else $error("identification shift wrong");

    id_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
        (dr_upd && sel_id) |=> (id_latch_r == $past(id_shift_r)))
        else $error("identification latch not loaded on update");

    ir_update_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ir_upd && !in_reset) |=> (ir_latch_r == $past(ir_shift_r)))
        else $error("instruction not latched on update");

endmodule : bsttr_regs

// ===== dv/bsttr_tester.sv
/* External boundary-scan tester model driving the test clock, mode and data.
 * Assumes clk is 100 MHz; one test clock period is 8 clk (80 ns). */
`timescale 1ns/1ps
module bsttr_tester
    import bsttr_pkg::*;
(
    // System
    input  wire logic      clk,
    // Test pins
    output bsttr_link_type pins,
    input  wire logic      tdo_in
);
    initial begin
        pins = '0;
    end
    // Read out just before the fall, where the output has stood a full phase
    // New values go out one edge after the fall, so no pin is written twice at once
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk);
        #1;
        pins.mode = m;
        pins.data = d;
        repeat (3) @(posedge clk);
        #1 pins.clk = 1'b1;
        repeat (4) @(posedge clk);
        #1 q = tdo_in;
        pins.clk = 1'b0;
        // Released data no longer shows the last value
        pins.data = ~d;
    endtask : step
    task automatic tap_reset();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
    endtask : tap_reset
    // From Idle through one scan and back to Idle; LSB first
    task automatic scan(input logic ir, input int n, input logic [39:0] din, output logic [39:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
endmodule : bsttr_tester

// ===== dv/testbench.sv
/* Self-checking bench for the test-port data registers.
 * Assumes the tester model in bsttr_tester drives all test pins. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench
    import bsttr_pkg::*;
();
    typedef struct packed {logic [2:0] code; logic tm; logic hz; logic [5:0] len;} bsttr_row_type;
    localparam logic [3:0]  T_REV   = 4'h3;    // Arbitrary value
    localparam logic [15:0] T_PART  = 16'h5C21; // Arbitrary value
    localparam logic [10:0] T_MAKER = 11'h1E7;  // Arbitrary value
    localparam logic [31:0] ID_EXP  = {T_REV, T_PART, T_MAKER, ID_FIXED_ONE};
    localparam logic [39:0] DIN     = 40'hC35A963CA5;
    logic               clk;
    logic               sys_rst;
    bsttr_link_type     pins;
    logic               tdo;
    logic               oe_n;
    logic               tm;
    logic               hz;
    logic [BSR_LEN-1:0] cap;
    logic [BSR_LEN-1:0] drv;
    logic [BSR_LEN-1:0] exp_drv;
    logic [39:0]        dout;
    logic [39:0]        cap_x;
    logic [39:0]        mask;
    logic               q;
    int                 len;
    int                 n_fail;
    int                 total_checks;
    bsttr_row_type      rows [8] = '{
        '{INS_EXTEST, 1'b1, 1'b0, BSR_LEN}, '{INS_IDCODE, 1'b0, 1'b0, ID_LEN},
        '{INS_SAMPLE, 1'b0, 1'b0, BSR_LEN}, '{INS_CLAMP, 1'b1, 1'b0, 6'd1},
        '{INS_HIGHZ, 1'b0, 1'b1, 6'd1}, '{INS_BYPASS, 1'b0, 1'b0, 6'd1},
        '{3'h5, 1'b0, 1'b0, 6'd1}, '{3'h6, 1'b0, 1'b0, 6'd1}};

    bsttr_regs #(.ID_REVISION(T_REV), .ID_PART(T_PART), .ID_MAKER(T_MAKER)) dut (
        .clk(clk), .sys_rst(sys_rst), .test_port_clock(pins.clk), .test_mode_select(pins.mode),
        .test_serial_in(pins.data), .test_serial_out(tdo), .test_serial_out_oe_n(oe_n),
        .cell_capture(cap), .cell_drive(drv), .cells_test_mode(tm), .cells_high_z(hz));
    bsttr_tester u_tst (.clk(clk), .pins(pins), .tdo_in(tdo));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        n_fail = 0;
        total_checks = 0;
        cap = 8'h96;
        exp_drv = '0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        `CHK("reset oe_n", 1'b1, oe_n)
        `CHK("reset drive", 8'h00, drv)
        `CHK("reset mode", 2'b00, {tm, hz})
        u_tst.step(1'b0, 1'b0, q);
        // One bit past the code shows the full register length
        u_tst.scan(1'b0, 33, DIN, dout);
        `CHK("id after reset", ID_EXP, dout[31:0])
        `CHK("id length", DIN[0], dout[32])
        $display("test reset_id done");
        for (int r = 0; r < 8; r++) begin
            u_tst.scan(1'b1, 3, {37'h0, rows[r].code}, dout);
            len = rows[r].len;
            `CHK("ir capture", IR_CAPTURE, dout[2:0])
            `CHK("cell mode", {rows[r].tm, rows[r].hz}, {tm, hz})
            `CHK("idle oe_n", 1'b1, oe_n)
            u_tst.scan(1'b0, len + 8, DIN, dout);
            mask = (40'h1 << len) - 40'h1;
            cap_x = (len == ID_LEN) ? {8'h0, ID_EXP} : (len == BSR_LEN) ? {32'h0, cap} : 40'h0;
            if (len == BSR_LEN) exp_drv = DIN[15:8];
            `CHK("capture", cap_x & mask, dout & mask)
            `CHK("path", DIN[7:0], dout[len +: 8])
            `CHK("cell drive", exp_drv, drv)
            $display("test row %0d done", r);
        end
        // Mode-select reset from mid-run clears EXTEST back to identify
        u_tst.scan(1'b1, 3, {37'h0, INS_EXTEST}, dout);
        u_tst.tap_reset();
        `CHK("tlr mode", 1'b0, tm)
        u_tst.step(1'b0, 1'b0, q);
        u_tst.scan(1'b0, 32, DIN, dout);
        `CHK("id after tlr", ID_EXP, dout[31:0])
        $display("test tap_reset done");
        u_tst.scan(1'b1, 3, {37'h0, INS_EXTEST}, dout);
        `CHK("extest mode", 2'b10, {tm, hz})
        @(posedge clk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        `CHK("mid reset drive", 8'h00, drv)
        `CHK("mid reset mode", 2'b00, {tm, hz})
        `CHK("mid reset oe_n", 1'b1, oe_n)
        u_tst.step(1'b0, 1'b0, q);
        u_tst.scan(1'b0, 32, DIN, dout);
        `CHK("id after mid reset", ID_EXP, dout[31:0])
        $display("test mid_reset done");
        wrap_up();
    end
endmodule : testbench
